//--- inc/psc_consts.svh
// pin state control constants: pin group sizes, reset values and bus offsets
`ifndef PSC_CONSTS_SVH
`define PSC_CONSTS_SVH

`define PSC_NPIN          32
`define PSC_NIRQ          16
`define PSC_ADDR_W        4
// -------------------------------------------------------------------
// register offsets (byte addresses)
// -------------------------------------------------------------------
`define PSC_OFF_CTRL      4'h0
`define PSC_OFF_STATUS    4'h4
`define PSC_OFF_IRQSEL    4'h8
`define PSC_OFF_ANALOG    4'hc
// -------------------------------------------------------------------
// control register fields and register reset values
// -------------------------------------------------------------------
`define PSC_CTRL_FLOAT    0
`define PSC_CTRL_EXTBUS   1
`define PSC_CTRL_RST      2'h0
`define PSC_IRQSEL_RST    32'h0000_0000
`define PSC_ANALOG_RST    32'h0000_0000

`endif

//--- inc/psc_pkg.sv
// pin state control types
package psc_pkg;
    typedef enum logic [2:0] {
        PSC_INIT_LOW,
        PSC_INIT_REL,
        PSC_RUN,
        PSC_SLEEP,
        PSC_STOP
    } psc_mode_e;
endpackage : psc_pkg

//--- core/psc_pin_gate.sv
// per-pin output driver and input gate
`timescale 1ns/1ns
module psc_pin_gate (
    input  wire logic clk_sys_i,
    input  wire logic rst_i,
    input  wire logic hold_i,
    input  wire logic hiz_i,
    input  wire logic force0_i,
    input  wire logic core_out_i,
    input  wire logic core_oe_i,
    input  wire logic pad_in_i,
    output logic      pad_out_o,
    output logic      pad_oe_o,
    output logic      core_in_o
);
    typedef struct packed {
        logic out;
        logic oe;
    } psc_gate_s;

    psc_gate_s st;
    psc_gate_s next_st;

    // latch the drive while awake, freeze it while holding
    always_comb begin
        next_st = st;
        if (!hold_i) begin
            next_st.out = core_out_i;
            next_st.oe  = core_oe_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // combinational selection so a new state takes effect at once
    assign pad_out_o = hold_i ? st.out : core_out_i; // R3 R10
    assign pad_oe_o  = hiz_i ? 1'b0 : (hold_i ? st.oe : core_oe_i); // R1 R4
    // the inward gate stays unregistered so a forced zero never lags the state change
    assign core_in_o = force0_i ? 1'b0 : pad_in_i; // R5 R8
endmodule : psc_pin_gate

//--- core/psc_pin_state.sv
// pin state control: drive and input gating of every pin by cpu state
`timescale 1ns/1ns
`include "psc_consts.svh"

// How it works
// (R1) init low: all outputs float, inputs disabled
// (R2) after init release: float, inputs on, analog zero
// (R3) sleep or stop without float: hold state
// (R4) stop with float: float and zero inputs
// (R5) forced inputs read constant zero inward
// (R6) nonmaskable irq input usable in every state
// (R7) float stop: enabled irq pins keep input
// (R8) disabled inputs never reach internal logic
// (R9) bus pins follow state; wait input handled
// (R10) state decode acts in same cycle
module psc_pin_state
    import psc_pkg::*;
(
    input  wire logic                     clk_sys_i,
    input  wire logic                     rst_i,
    input  wire logic                     init_pin_low_active_i,
    input  wire logic                     sleep_i,
    input  wire logic                     stop_i,
    input  wire logic [`PSC_NPIN-1:0]     core_out_i,
    input  wire logic [`PSC_NPIN-1:0]     core_oe_i,
    input  wire logic [`PSC_NPIN-1:0]     pad_in_i,
    output logic      [`PSC_NPIN-1:0]     pad_out_o,
    output logic      [`PSC_NPIN-1:0]     pad_oe_o,
    output logic      [`PSC_NPIN-1:0]     core_in_o,
    input  wire logic [`PSC_NIRQ-1:0]     ext_irq_enable_i,
    input  wire logic                     nonmaskable_irq_pin_i,
    output logic                          nonmaskable_irq_o,
    input  wire logic                     bus_wait_pin_i,
    output logic                          bus_wait_o,
    input  wire logic [`PSC_ADDR_W-1:0]   avs_address,
    input  wire logic                     avs_read,
    input  wire logic                     avs_write,
    input  wire logic [31:0]              avs_writedata,
    input  wire logic [3:0]               avs_byteenable,
    output logic      [31:0]              avs_readdata,
    output logic                          avs_waitrequest,
    output psc_mode_e                     mode_o
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [1:0]            ctrl;
        logic [`PSC_NPIN-1:0]  irqsel;
        logic [`PSC_NPIN-1:0]  analog;
        logic                  was_init;
        logic                  ack;
        logic [31:0]           rdata;
    } psc_state_s;

    psc_state_s st;
    psc_state_s next_st;
    psc_mode_e  mode;

    // byte-lane merge used by every writable register
    function automatic logic [31:0] psc_merge(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction : psc_merge

    // ---------------------------------------------------------------
    // cpu state decode
    // ---------------------------------------------------------------
    // init low wins over everything, release state lasts until the cpu
    // reports sleep/stop or software acknowledges via any register write
    always_comb begin
        if (!init_pin_low_active_i) begin
            mode = PSC_INIT_LOW; // R10
        end else if (stop_i) begin
            mode = PSC_STOP;
        end else if (sleep_i) begin
            mode = PSC_SLEEP;
        end else if (st.was_init) begin
            mode = PSC_INIT_REL;
        end else begin
            mode = PSC_RUN;
        end
    end

    logic float_on;
    logic extbus;
    logic hold;
    logic hiz_all;
    logic in_off_all;
    assign float_on   = st.ctrl[`PSC_CTRL_FLOAT];
    assign extbus     = st.ctrl[`PSC_CTRL_EXTBUS];
    // hold covers sleep and non-float stop
    assign hold       = (mode == PSC_SLEEP) || (mode == PSC_STOP && !float_on); // R3 R9
    assign hiz_all    = (mode == PSC_INIT_LOW) || (mode == PSC_INIT_REL)
                        || (mode == PSC_STOP && float_on); // R1 R2 R4 R9
    assign in_off_all = (mode == PSC_INIT_LOW) || (mode == PSC_STOP && float_on); // R1 R4

    // ---------------------------------------------------------------
    // per-pin gating
    // ---------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `PSC_NPIN; g++) begin : g_pin
            logic f0;
            logic irq_ok;
            if (g < `PSC_NIRQ) begin : g_irq
                assign irq_ok = st.irqsel[g] && ext_irq_enable_i[g]; // R7
            end else begin : g_plain
                assign irq_ok = 1'b0;
            end
            assign f0 = (in_off_all && !(mode == PSC_STOP && irq_ok)) // R4 R7 R8
                        || (mode == PSC_INIT_REL && st.analog[g]); // R2
            psc_pin_gate u_gate (
                .clk_sys_i  (clk_sys_i),
                .rst_i      (rst_i),
                .hold_i     (hold),
                .hiz_i      (hiz_all),
                .force0_i   (f0),
                .core_out_i (core_out_i[g]),
                .core_oe_i  (core_oe_i[g]),
                .pad_in_i   (pad_in_i[g]),
                .pad_out_o  (pad_out_o[g]),
                .pad_oe_o   (pad_oe_o[g]),
                .core_in_o  (core_in_o[g])
            );
        end
    endgenerate

    // nonmaskable pin bypasses all gating
    assign nonmaskable_irq_o = nonmaskable_irq_pin_i; // R6
    // wait input off in init and float stop; bus mode also keeps it off after release
    assign bus_wait_o = (in_off_all || (extbus && mode == PSC_INIT_REL)) ? 1'b0
                        : bus_wait_pin_i; // R8 R9
    assign mode_o     = mode;

    // ---------------------------------------------------------------
    // register bus
    // ---------------------------------------------------------------
    // one wait state per access keeps read data registered
    assign avs_waitrequest = (avs_read || avs_write) && !st.ack;
    assign avs_readdata    = st.rdata;

    always_comb begin
        next_st = st;
        next_st.ack = (avs_read || avs_write) && !st.ack;
        // init low wins over a clearing write in the same cycle
        if (mode == PSC_INIT_LOW) begin
            next_st.was_init = 1'b1;
        end else if (mode == PSC_SLEEP || mode == PSC_STOP || (avs_write && st.ack)) begin
            next_st.was_init = 1'b0;
        end
        // a write lands only on the edge that sees waitrequest low
        if (avs_write && st.ack) begin
            case (avs_address)
                `PSC_OFF_CTRL: begin
                    next_st.ctrl = 2'(psc_merge({30'h0, st.ctrl}, avs_writedata,
                                                avs_byteenable));
                end
                `PSC_OFF_IRQSEL: begin
                    next_st.irqsel = psc_merge(st.irqsel, avs_writedata,
                                               avs_byteenable) & 32'h0000_ffff;
                end
                `PSC_OFF_ANALOG: begin
                    next_st.analog = psc_merge(st.analog, avs_writedata,
                                               avs_byteenable);
                end
                default: begin
                end
            endcase
        end
        if (avs_read && !st.ack) begin
            case (avs_address)
                `PSC_OFF_CTRL:   next_st.rdata = {30'h0, st.ctrl};
                `PSC_OFF_STATUS: next_st.rdata = {29'h0, mode};
                `PSC_OFF_IRQSEL: next_st.rdata = st.irqsel;
                `PSC_OFF_ANALOG: next_st.rdata = st.analog;
                default:         next_st.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            st.ctrl     <= `PSC_CTRL_RST;
            st.irqsel   <= `PSC_IRQSEL_RST;
            st.analog   <= `PSC_ANALOG_RST;
            st.was_init <= 1'b1;
            st.ack      <= 1'b0;
            st.rdata    <= 32'h0000_0000;
        end else begin
            st <= next_st;
        end
    end
endmodule : psc_pin_state

//--- dv/psc_pin_state_assertions.sv
// port checker for pin state control
`timescale 1ns/1ns
`include "psc_consts.svh"
module psc_pin_state_chk
    import psc_pkg::*;
(
    input wire logic                 clk_sys_i,
    input wire logic                 rst_i,
    input wire logic                 init_pin_low_active_i,
    input wire logic                 sleep_i,
    input wire logic                 stop_i,
    input wire logic [`PSC_NPIN-1:0] pad_in_i,
    input wire logic [`PSC_NPIN-1:0] pad_out_o,
    input wire logic [`PSC_NPIN-1:0] pad_oe_o,
    input wire logic [`PSC_NPIN-1:0] core_in_o,
    input wire logic                 nonmaskable_irq_pin_i,
    input wire logic                 nonmaskable_irq_o,
    input wire logic                 bus_wait_o,
    input wire psc_mode_e            mode_o
);
    // -------------------------------------------------------------
    // pin state relations, all in the system clock domain
    // -------------------------------------------------------------
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    a_init_float: assert property (!init_pin_low_active_i |-> pad_oe_o == '0)
        else $error("pad driven in init");
    a_init_gate: assert property (!init_pin_low_active_i |-> core_in_o == '0 && !bus_wait_o)
        else $error("input live in init");
    a_init_mode: assert property (!init_pin_low_active_i |-> mode_o == PSC_INIT_LOW)
        else $error("init not decoded");
    a_rel_float: assert property (mode_o == PSC_INIT_REL |-> pad_oe_o == '0)
        else $error("pad driven after release");
    // the gate passes the pad level or a zero, never a one of its own
    a_gate_zero: assert property ((core_in_o & ~pad_in_i) == '0)
        else $error("core one with pad low");
    a_nmi_pass: assert property (nonmaskable_irq_o == nonmaskable_irq_pin_i)
        else $error("nmi blocked");
    a_sleep_mode: assert property (init_pin_low_active_i && sleep_i && !stop_i |->
        mode_o == PSC_SLEEP) else $error("sleep not decoded");
    a_hold_drive: assert property ((init_pin_low_active_i && sleep_i && !stop_i) [*2] |->
        $stable(pad_out_o) && $stable(pad_oe_o)) else $error("drive moved in sleep");
    c_sleep: cover property (mode_o == PSC_SLEEP);
    c_stop: cover property (mode_o == PSC_STOP);
    c_rel: cover property (mode_o == PSC_INIT_REL);
endmodule : psc_pin_state_chk

bind psc_pin_state psc_pin_state_chk u_chk (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .init_pin_low_active_i(init_pin_low_active_i),
    .sleep_i(sleep_i), .stop_i(stop_i), .pad_in_i(pad_in_i), .pad_out_o(pad_out_o),
    .pad_oe_o(pad_oe_o),
    .core_in_o(core_in_o), .nonmaskable_irq_pin_i(nonmaskable_irq_pin_i),
    .nonmaskable_irq_o(nonmaskable_irq_o), .bus_wait_o(bus_wait_o), .mode_o(mode_o));

//--- dv/psc_board_model.sv
// board circuitry on the pads: device drive where enabled, board level elsewhere
`timescale 1ns/1ns
`include "psc_consts.svh"
module psc_board_model (
    input  wire logic [`PSC_NPIN-1:0] pad_out_i,
    input  wire logic [`PSC_NPIN-1:0] pad_oe_i,
    input  wire logic [`PSC_NPIN-1:0] board_lvl_i,
    output logic      [`PSC_NPIN-1:0] pad_o
);
    // a released pad shows the board level, which changes every cycle, not the last drive
    assign pad_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & board_lvl_i);
endmodule : psc_board_model

//--- dv/psc_pin_state_bench.sv
// self-checking bench for pin state control
`timescale 1ns/1ns
`include "psc_consts.svh"
module psc_pin_state_bench;
    import psc_pkg::*;
    logic        clk_sys_i, rst_i, init_n, sleep, stop, nmi_pin, wait_pin, rd, wr, nmi, bwait;
    logic        wreq;
    logic [3:0]  adr;
    logic [15:0] lf = 16'he6ac, irq_en, sel;
    logic [31:0] cout, coe, lvl, wdat, rdat, got, pad_in, pad_out, pad_oe, core_in, hout, hoe, msk;
    psc_mode_e   mode;
    int          n_errors = 0;
    int          compares = 0;
    psc_pin_state uut (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .init_pin_low_active_i(init_n), .sleep_i(sleep),
        .stop_i(stop), .core_out_i(cout), .core_oe_i(coe), .pad_in_i(pad_in),
        .pad_out_o(pad_out), .pad_oe_o(pad_oe), .core_in_o(core_in), .ext_irq_enable_i(irq_en),
        .nonmaskable_irq_pin_i(nmi_pin), .nonmaskable_irq_o(nmi), .bus_wait_pin_i(wait_pin),
        .bus_wait_o(bwait), .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wdat), .avs_byteenable(4'hf), .avs_readdata(rdat),
        .avs_waitrequest(wreq), .mode_o(mode));
    psc_board_model u_board (.pad_out_i(pad_out), .pad_oe_i(pad_oe), .board_lvl_i(lvl),
        .pad_o(pad_in));
    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    function automatic logic [31:0] rnd();
        for (int i = 0; i < 32; i++) begin
            lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
            rnd[i] = lf[0];
        end
    endfunction : rnd
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic print_verdict();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    // request held until waitrequest is seen low at an edge; one idle edge after release
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        adr <= a;
        wdat <= d;
        rd <= !w;
        wr <= w;
        do @(posedge clk_sys_i); while (wreq !== 1'b0);
        got = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk_sys_i);
    endtask : bus
    // fresh drive, enables and board levels every cycle
    task automatic stim();
        cout <= rnd();
        coe <= rnd();
        lvl <= rnd();
        {nmi_pin, wait_pin, irq_en} <= 18'(rnd());
        @(posedge clk_sys_i);
    endtask : stim
    initial begin
        repeat (3000) @(posedge clk_sys_i);
        n_errors++;
        print_verdict();
    end
    initial begin
        {init_n, sleep, stop, nmi_pin, wait_pin, rd, wr, adr, irq_en} = '0;
        {cout, coe, lvl, wdat} = '0;
        rst_i = 1'b1;
        repeat (4) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        // init held: nothing drives, only the nmi input reaches the core
        repeat (3) begin
            stim();
            chk(pad_oe, '0);
            chk(core_in, '0);
            chk(32'(nmi), 32'(nmi_pin));
            chk(32'(bwait), '0);
        end
        init_n <= 1'b1;
        stim();
        chk(32'(mode), 32'(PSC_INIT_REL));
        chk(pad_oe, '0);
        chk(core_in, pad_in);
        msk = rnd();
        sel = 16'(rnd());
        bus(1'b1, `PSC_OFF_ANALOG, msk);
        bus(1'b1, `PSC_OFF_IRQSEL, {16'h0, sel});
        bus(1'b0, `PSC_OFF_ANALOG, '0);
        chk(got, msk);
        bus(1'b0, 4'h2, '0);
        chk(got, '0);
        bus(1'b0, `PSC_OFF_STATUS, '0);
        chk(got, 32'(PSC_RUN));
        // a second init pulse keeps the registers, so masked analog pins read zero
        init_n <= 1'b0;
        stim();
        init_n <= 1'b1;
        stim();
        chk(core_in, pad_in & ~msk);
        // sleep, then stop without float: drive of the cycle before entry is kept
        for (int k = 0; k < 2; k++) begin
            bus(1'b1, `PSC_OFF_CTRL, '0);
            stim();
            hout = cout;
            hoe = coe;
            sleep <= (k == 0);
            stop <= (k == 1);
            repeat (3) begin
                stim();
                chk(pad_out & hoe, hout & hoe);
                chk(pad_oe, hoe);
            end
            {sleep, stop} <= 2'b00;
        end
        // stop with float, plain and external bus mode
        for (int c = 1; c < 4; c += 2) begin
            bus(1'b1, `PSC_OFF_CTRL, 32'(c));
            stop <= 1'b1;
            repeat (3) begin
                stim();
                chk(pad_oe, '0);
                chk(core_in, pad_in & {16'h0, sel & irq_en});
                chk(32'(bwait), '0);
            end
            stop <= 1'b0;
        end
        print_verdict();
    end
endmodule : psc_pin_state_bench
